// file: design/jvl_ctrl.v
// vpw link transmit control: loopback, fast receive, framing, crc and in-frame response
// assumes synchronous link pins, active-high bus level and a 200 MHz clock
//
// How it works
// - digital loopback feeds transmit into receive
// - loopback clear: bus driven and received normally
// - after loopback, reception waits end-of-frame idle
// - after loopback, transmission waits inter-frame idle
// - fast select: receive only at 41.6 kbps
// - fast clear: send and receive at 10.4
// - break clears fast select, loads vector 001C
// - format select picks normalization bit value
// - end request: finish byte, crc, end symbol
// - shadow byte goes out before the crc
// - end request clears transmit empty flag
// - main frame: end request clears at crc
// - crc or no-crc response: end request clears on echoed end
// - several response requests: priority picks one
// - response request bits read back as written
// - losing single-byte responder repeats byte until seen
// - active normalization bit precedes response byte
// - one shared normalization bit syncs responders
// - analog loopback: bus not driven
//
// Local design decisions: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
`include "jvl_map.vh"

module jvl_ctrl #(
  parameter CLK_MHZ = `JVL_CLK_MHZ
) (
  input wire clk,
  input wire resetn,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire link_receive_input,
  output reg link_transmit_output,
  output reg analog_loopback_out
);

  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_SOF = 3'h1;
  localparam [2:0] S_BITS = 3'h2;
  localparam [2:0] S_EOD = 3'h3;
  localparam [2:0] S_NB = 3'h4;
  localparam [2:0] S_RETRY = 3'h5;
  // divider reloads worked out wide, then cut to the counter width on purpose
  localparam integer DIV_NORM_I = CLK_MHZ * `JVL_TICK_US - 1;
  localparam integer DIV_FAST_I = CLK_MHZ * `JVL_TICK_US / `JVL_FAST_FACTOR - 1;
  localparam [7:0] DIV_NORM = DIV_NORM_I[7:0];
  localparam [7:0] DIV_FAST = DIV_FAST_I[7:0];

  // one crc-8 step over a whole byte, msb first
  function [7:0] crc8;
    input [7:0] c;
    input [7:0] d;
    integer i;
    reg [7:0] x;
    begin
      x = c;
      for (i = 7; i >= 0; i = i - 1) begin
        if (x[7] ^ d[i])
          x = {x[6:0], 1'b0} ^ `JVL_CRC_POLY;
        else
          x = {x[6:0], 1'b0};
      end
      crc8 = x;
    end
  endfunction

  // vpw symbol length for a data bit at the given level
  function [8:0] sym_len;
    input act;
    input b;
    begin
      sym_len = (act ^ b) ? `JVL_T_LONG : `JVL_T_SHORT;
    end
  endfunction

  reg ack_r;
  reg digital_loopback_r, analog_loopback_r, fast_r, norm_bit_format_select_r, end_of_data_request_r;
  reg [2:0] ifr_w_r;
  reg [7:0] div_r;
  reg tick_r;
  reg rx_q_r;
  reg [8:0] rx_cnt_r;
  reg [2:0] rx_bit_r;
  reg [7:0] rx_sr_r, rx_data_r, rx_crc_r;
  reg rx_full_r, in_frame_r, nb_skip_r, crc_ok_r;
  reg rx_blk_r, tx_blk_r, brk_r, lost_r;
  reg [2:0] st_r;
  reg tx_act_r, crc_on_r, ifr_r;
  reg [8:0] tx_cnt_r;
  reg [2:0] tx_bit_r;
  reg [7:0] tx_sr_r, tx_byte_r, tx_crc_r, sh_r;
  reg sh_full_r, tx_data_empty_flag_r;

  // bus handshake: one wait cycle, then the request is taken
  wire req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_r;
  wire wr_go = avs_write & ack_r;
  wire rd_go = avs_read & ack_r;
  wire wr_ctrl = wr_go & (avs_address == `JVL_ADDR_CTRL);
  wire wr_data = wr_go & (avs_address == `JVL_ADDR_DATA);
  wire rd_svec = rd_go & (avs_address == `JVL_ADDR_SVEC);
  wire rd_data = rd_go & (avs_address == `JVL_ADDR_DATA);

  // priority-encoded response request, raw bits kept for readback
  wire eff_single = ifr_w_r[2];
  wire eff_crc = ~ifr_w_r[2] & ifr_w_r[1];
  wire eff_nocrc = ~ifr_w_r[2] & ~ifr_w_r[1] & ifr_w_r[0];
  wire ifr_any = eff_single | eff_crc | eff_nocrc;
  // normalization bit: 1 is a short active, 0 a long active
  wire nb_one = eff_crc ? ~norm_bit_format_select_r : norm_bit_format_select_r;
  wire [8:0] nb_len = nb_one ? `JVL_T_SHORT : `JVL_T_LONG;

  // receive source: own transmit level in digital loopback, else the pin
  wire rx_line = digital_loopback_r ? tx_act_r : link_receive_input;
  wire rx_edge = rx_line ^ rx_q_r;
  wire rx_bit = rx_q_r ? (rx_cnt_r < `JVL_R_LONG_MIN) : (rx_cnt_r >= `JVL_R_LONG_MIN);
  wire rx_is_bit = ~rx_q_r ? (rx_cnt_r < `JVL_R_SOF_MIN)
                           : (rx_cnt_r < `JVL_R_SOF_MIN) & ~nb_skip_r;
  wire rx_byte = rx_edge & rx_is_bit & (rx_bit_r == 3'h7);
  wire [7:0] rx_new = {rx_sr_r[6:0], rx_bit};
  wire rx_eod = tick_r & ~rx_q_r & in_frame_r & (rx_cnt_r == `JVL_R_SOF_MIN - 9'h001);
  wire rx_brk = rx_edge & rx_q_r & (rx_cnt_r >= `JVL_R_EOF_MIN);

  // current transmit symbol length and end of symbol
  reg [8:0] dur;
  always @* begin
    case (st_r)
      S_SOF: dur = `JVL_T_SOF;
      S_NB: dur = nb_len;
      S_EOD: dur = `JVL_T_EOD;
      S_BITS: dur = sym_len(tx_act_r, tx_sr_r[7]);
      default: dur = `JVL_T_MAX;
    endcase
  end
  wire sym_end = tick_r & (tx_cnt_r == dur - 9'h001);
  wire sending = (st_r == S_SOF) | (st_r == S_BITS) | (st_r == S_NB);
  // own passive symbol but bus active: another node won
  wire lost = tick_r & sending & ~tx_act_r & rx_q_r & (tx_cnt_r != 9'h000);
  wire bus_idle = ~rx_q_r & ~in_frame_r & (rx_cnt_r >= `JVL_T_IFS);
  wire can_tx = ~fast_r & ~tx_blk_r & sh_full_r;
  wire go_main = (st_r == S_IDLE) & can_tx & bus_idle & ~ifr_any;
  wire go_ifr = (st_r == S_IDLE) & can_tx & ifr_any & rx_eod & crc_ok_r;

  // state vector: break above lost arbitration above transmit empty above receive
  reg [15:0] svec;
  always @* begin
    if (brk_r)
      svec = `JVL_SV_BREAK;
    else if (lost_r)
      svec = `JVL_SV_LOST;
    else if (tx_data_empty_flag_r & (st_r != S_IDLE))
      svec = `JVL_SV_TX_DATA_EMPTY_FLAG;
    else if (rx_full_r)
      svec = `JVL_SV_RXFULL;
    else
      svec = `JVL_SV_NONE;
  end

  // register read mux, latched during the wait cycle
  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (avs_address)
      `JVL_ADDR_CTRL: begin
        rd_mux[`JVL_C_DIGITAL_LOOPBACK] = digital_loopback_r;
        rd_mux[`JVL_C_ANALOG_LOOPBACK] = analog_loopback_r;
        rd_mux[`JVL_C_FAST] = fast_r;
        rd_mux[`JVL_C_NORM_BIT_FORMAT_SELECT] = norm_bit_format_select_r;
        rd_mux[`JVL_C_END_OF_DATA_REQUEST] = end_of_data_request_r;
        rd_mux[`JVL_C_MNOCRC] = ifr_w_r[0];
        rd_mux[`JVL_C_MCRC] = ifr_w_r[1];
        rd_mux[`JVL_C_SINGLE] = ifr_w_r[2];
      end
      `JVL_ADDR_SVEC: rd_mux[15:0] = svec;
      `JVL_ADDR_STAT: begin
        rd_mux[`JVL_S_TX_DATA_EMPTY_FLAG] = tx_data_empty_flag_r;
        rd_mux[`JVL_S_RXFULL] = rx_full_r;
        rd_mux[`JVL_S_BUSY] = st_r != S_IDLE;
        rd_mux[`JVL_S_RXBLK] = rx_blk_r;
        rd_mux[`JVL_S_TXBLK] = tx_blk_r;
        rd_mux[`JVL_S_LOST] = lost_r;
        rd_mux[`JVL_S_INFRM] = in_frame_r;
        rd_mux[`JVL_S_CRCOK] = crc_ok_r;
      end
      `JVL_ADDR_DATA: rd_mux[7:0] = rx_data_r;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // bus slave flops and pin drivers
  always @(posedge clk) begin
    if (!resetn) begin
      ack_r <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      link_transmit_output <= 1'b0;
      analog_loopback_out <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
      if (avs_read & ~ack_r)
        avs_readdata <= rd_mux;
      // never drive the bus in either loopback
      link_transmit_output <= tx_act_r & ~digital_loopback_r & ~analog_loopback_r;
      analog_loopback_out <= analog_loopback_r;
    end
  end

  // 1 us tick, four times faster in fast receive mode
  always @(posedge clk) begin
    if (!resetn) begin
      div_r <= 8'h00;
      tick_r <= 1'b0;
    end else begin
      tick_r <= 1'b0;
      if (div_r == 8'h00) begin
        div_r <= fast_r ? DIV_FAST : DIV_NORM;
        tick_r <= 1'b1;
      end else
        div_r <= div_r - 8'h01;
    end
  end

  // receive symbol decoder and loopback idle gating
  always @(posedge clk) begin
    if (!resetn) begin
      rx_q_r <= 1'b0;
      rx_cnt_r <= 9'h000;
      rx_bit_r <= 3'h0;
      rx_sr_r <= 8'h00;
      rx_data_r <= 8'h00;
      rx_crc_r <= `JVL_CRC_INIT;
      rx_full_r <= 1'b0;
      in_frame_r <= 1'b0;
      nb_skip_r <= 1'b0;
      crc_ok_r <= 1'b0;
      rx_blk_r <= 1'b0;
      tx_blk_r <= 1'b0;
      brk_r <= 1'b0;
    end else begin
      rx_q_r <= rx_line;
      if (rx_edge)
        rx_cnt_r <= 9'h000;
      else if (tick_r & (rx_cnt_r != `JVL_T_MAX))
        rx_cnt_r <= rx_cnt_r + 9'h001;
      if (rx_edge & rx_q_r & (rx_cnt_r >= `JVL_R_SOF_MIN) & ~rx_brk) begin
        in_frame_r <= 1'b1;
        nb_skip_r <= 1'b0;
        rx_bit_r <= 3'h0;
        rx_crc_r <= `JVL_CRC_INIT;
      end else if (rx_edge & rx_q_r & nb_skip_r) begin
        nb_skip_r <= 1'b0;
        rx_crc_r <= `JVL_CRC_INIT;
      end else if (rx_edge & rx_is_bit & in_frame_r) begin
        rx_sr_r <= rx_new;
        rx_bit_r <= rx_bit_r + 3'h1;
        if (rx_byte) begin
          rx_crc_r <= crc8(rx_crc_r, rx_new);
          if (~rx_blk_r) begin
            rx_data_r <= rx_new;
            rx_full_r <= 1'b1;
          end
        end
      end
      // end of data: a normalization bit may follow
      if (rx_eod) begin
        nb_skip_r <= 1'b1;
        rx_bit_r <= 3'h0;
        crc_ok_r <= rx_crc_r == `JVL_CRC_RESID;
      end
      if (tick_r & ~rx_q_r & (rx_cnt_r == `JVL_R_EOF_MIN - 9'h001))
        in_frame_r <= 1'b0;
      if (rx_brk) begin
        in_frame_r <= 1'b0;
        brk_r <= 1'b1;
      end else if (rd_svec)
        brk_r <= 1'b0;
      if (rd_data & ~(rx_byte & in_frame_r & ~rx_blk_r))
        rx_full_r <= 1'b0;
      // idle bus releases reception, then transmission
      if (~rx_q_r & (rx_cnt_r >= `JVL_T_EOF))
        rx_blk_r <= 1'b0;
      if (~rx_q_r & (rx_cnt_r >= `JVL_T_IFS))
        tx_blk_r <= 1'b0;
      // leaving either loopback restarts the idle wait
      if (wr_ctrl & ((digital_loopback_r & ~avs_writedata[`JVL_C_DIGITAL_LOOPBACK])
                   | (analog_loopback_r & ~avs_writedata[`JVL_C_ANALOG_LOOPBACK]))) begin
        rx_blk_r <= 1'b1;
        tx_blk_r <= 1'b1;
        rx_cnt_r <= 9'h000;
      end
    end
  end

  // transmit framer, control bits and shadow register
  always @(posedge clk) begin
    if (!resetn) begin
      digital_loopback_r <= 1'b0;
      analog_loopback_r <= 1'b0;
      fast_r <= 1'b0;
      norm_bit_format_select_r <= 1'b0;
      end_of_data_request_r <= 1'b0;
      ifr_w_r <= 3'h0;
      st_r <= S_IDLE;
      tx_act_r <= 1'b0;
      tx_cnt_r <= 9'h000;
      tx_bit_r <= 3'h0;
      tx_sr_r <= 8'h00;
      tx_byte_r <= 8'h00;
      tx_crc_r <= `JVL_CRC_INIT;
      crc_on_r <= 1'b0;
      ifr_r <= 1'b0;
      sh_r <= 8'h00;
      sh_full_r <= 1'b0;
      tx_data_empty_flag_r <= 1'b1;
      lost_r <= 1'b0;
    end else begin
      if (tick_r & (st_r != S_IDLE) & (st_r != S_RETRY))
        tx_cnt_r <= tx_cnt_r + 9'h001;
      if (go_main | go_ifr) begin
        tx_sr_r <= sh_r;
        tx_byte_r <= sh_r;
        sh_full_r <= 1'b0;
        tx_data_empty_flag_r <= 1'b1;
        tx_crc_r <= crc8(`JVL_CRC_INIT, sh_r);
        crc_on_r <= 1'b0;
        tx_bit_r <= 3'h0;
        tx_cnt_r <= 9'h000;
        tx_act_r <= 1'b1;
        ifr_r <= go_ifr;
        st_r <= go_ifr ? S_NB : S_SOF;
      end else if (rx_brk & (st_r != S_IDLE)) begin
        st_r <= S_IDLE;
        tx_act_r <= 1'b0;
        end_of_data_request_r <= 1'b0;
        ifr_w_r <= 3'h0;
        ifr_r <= 1'b0;
      end else if (lost) begin
        lost_r <= 1'b1;
        tx_act_r <= 1'b0;
        if (ifr_r & eff_single)
          st_r <= S_RETRY;
        else begin
          st_r <= S_IDLE;
          end_of_data_request_r <= 1'b0;
          ifr_w_r <= 3'h0;
          ifr_r <= 1'b0;
        end
      end else if (st_r == S_RETRY) begin
        if (rx_byte & (rx_new == tx_byte_r)) begin
          st_r <= S_IDLE;
          ifr_r <= 1'b0;
        end else if (rx_byte) begin
          tx_sr_r <= tx_byte_r;
          tx_bit_r <= 3'h0;
          tx_cnt_r <= 9'h000;
          tx_act_r <= rx_line;
          st_r <= S_BITS;
        end else if (~in_frame_r) begin
          st_r <= S_IDLE;
          ifr_w_r <= 3'h0;
          ifr_r <= 1'b0;
        end
      end else if (sym_end) begin
        tx_cnt_r <= 9'h000;
        tx_act_r <= 1'b0;
        case (st_r)
          S_SOF, S_NB: st_r <= S_BITS;
          S_EOD: begin
            st_r <= S_IDLE;
            ifr_r <= 1'b0;
          end
          S_BITS: begin
            tx_act_r <= ~tx_act_r;
            tx_sr_r <= {tx_sr_r[6:0], 1'b0};
            tx_bit_r <= tx_bit_r + 3'h1;
            if (tx_bit_r == 3'h7) begin
              if (crc_on_r | (ifr_r & eff_single)) begin
                crc_on_r <= 1'b0;
                tx_act_r <= 1'b0;
                st_r <= S_EOD;
              end else if (sh_full_r) begin
                tx_sr_r <= sh_r;
                tx_byte_r <= sh_r;
                sh_full_r <= 1'b0;
                tx_data_empty_flag_r <= 1'b1;
                tx_crc_r <= crc8(tx_crc_r, sh_r);
              end else if (end_of_data_request_r & ifr_r & ~eff_crc) begin
                tx_act_r <= 1'b0;
                st_r <= S_EOD;
              end else if (end_of_data_request_r) begin
                tx_sr_r <= ~tx_crc_r;
                crc_on_r <= 1'b1;
                if (~ifr_r)
                  end_of_data_request_r <= 1'b0;
              end else begin
                // underrun ends the frame without an end symbol
                tx_act_r <= 1'b0;
                st_r <= S_IDLE;
                ifr_w_r <= ifr_r ? 3'h0 : ifr_w_r;
                ifr_r <= 1'b0;
              end
            end
          end
          default: st_r <= S_IDLE;
        endcase
      end
      // crc and no-crc responses close when their end symbol is seen on the bus
      if (rx_eod & ifr_r & (st_r == S_EOD) & ~eff_single) begin
        end_of_data_request_r <= 1'b0;
        ifr_w_r <= 3'h0;
      end
      if (rx_byte & ifr_r & eff_single & (rx_new == tx_byte_r))
        ifr_w_r <= 3'h0;
      if (rd_svec)
        lost_r <= lost;
      // break wins over software so fast receive always drops back
      if (rx_brk)
        fast_r <= 1'b0;
      if (wr_ctrl) begin
        digital_loopback_r <= avs_writedata[`JVL_C_DIGITAL_LOOPBACK];
        analog_loopback_r <= avs_writedata[`JVL_C_ANALOG_LOOPBACK];
        if (~rx_brk)
          fast_r <= avs_writedata[`JVL_C_FAST];
        norm_bit_format_select_r <= avs_writedata[`JVL_C_NORM_BIT_FORMAT_SELECT];
        // raw value stored; the encoded view is derived
        ifr_w_r <= {avs_writedata[`JVL_C_SINGLE], avs_writedata[`JVL_C_MCRC],
                    avs_writedata[`JVL_C_MNOCRC]};
        if (avs_writedata[`JVL_C_END_OF_DATA_REQUEST]) begin
          end_of_data_request_r <= 1'b1;
          tx_data_empty_flag_r <= 1'b0;
        end
      end
      if (wr_data) begin
        sh_r <= avs_writedata[7:0];
        sh_full_r <= 1'b1;
        tx_data_empty_flag_r <= 1'b0;
      end
    end
  end

endmodule

// file: design/jvl_map.vh
// register map, field positions and symbol timing of the vpw link control block
// assumes a 32-bit avalon-mm slave with byte addresses and a 1 us timing tick
`ifndef JVL_MAP_VH
`define JVL_MAP_VH
// byte offsets of the four word registers
`define JVL_ADDR_CTRL 4'h0
`define JVL_ADDR_SVEC 4'h4
`define JVL_ADDR_STAT 4'h8
`define JVL_ADDR_DATA 4'hC
// control register fields
`define JVL_C_DIGITAL_LOOPBACK 0
`define JVL_C_ANALOG_LOOPBACK 1
`define JVL_C_FAST 2
`define JVL_C_NORM_BIT_FORMAT_SELECT 3
`define JVL_C_END_OF_DATA_REQUEST 4
`define JVL_C_MNOCRC 5
`define JVL_C_MCRC 6
`define JVL_C_SINGLE 7
// status register fields
`define JVL_S_TX_DATA_EMPTY_FLAG 0
`define JVL_S_RXFULL 1
`define JVL_S_BUSY 2
`define JVL_S_RXBLK 3
`define JVL_S_TXBLK 4
`define JVL_S_LOST 5
`define JVL_S_INFRM 6
`define JVL_S_CRCOK 7
// state vector codes
`define JVL_SV_NONE 16'h0000
`define JVL_SV_BREAK 16'h001C
`define JVL_SV_LOST 16'h0008
`define JVL_SV_TX_DATA_EMPTY_FLAG 16'h000C
`define JVL_SV_RXFULL 16'h0010
// clock and tick
`define JVL_CLK_MHZ 200
`define JVL_TICK_US 1
`define JVL_FAST_FACTOR 4
// symbol lengths in us, transmit side
`define JVL_T_SHORT 9'h040
`define JVL_T_LONG 9'h080
`define JVL_T_SOF 9'h0C8
`define JVL_T_EOD 9'h0C8
`define JVL_T_EOF 9'h118
`define JVL_T_IFS 9'h12C
`define JVL_T_MAX 9'h1FF
// receive classification limits in us
`define JVL_R_LONG_MIN 9'h060
`define JVL_R_SOF_MIN 9'h0A4
`define JVL_R_EOF_MIN 9'h0F0
// crc-8, polynomial x8+x4+x3+x2+1
`define JVL_CRC_INIT 8'hFF
`define JVL_CRC_POLY 8'h1D
`define JVL_CRC_RESID 8'hC4
`endif

// file: verification/jvl_ctrl_sva.sv
// checker for the vpw link control block, bound to its top ports
// assumes one wait cycle per avalon request and a tick of CLK_MHZ clocks
`timescale 1ns/10ps
`include "jvl_map.vh"
module jvl_ctrl_sva #(
  parameter CLK_MHZ = 200
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic link_receive_input,
  input wire logic link_transmit_output,
  input wire logic analog_loopback_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic digital_loopback_r, analog_loopback_r, fast_r, gate_r;
  logic [2:0] resp_r;
  int act_r, pas_r;
  wire logic wr_ctrl = avs_write && !avs_waitrequest && avs_address == `JVL_ADDR_CTRL;
  wire logic rd_ok = avs_read && !avs_waitrequest;
  // control bits as software left them, plus line run counters
  always @(posedge clk) begin
    if (!resetn) begin
      digital_loopback_r <= 1'b0;
      analog_loopback_r <= 1'b0;
      fast_r <= 1'b0;
      gate_r <= 1'b0;
      resp_r <= 3'h0;
      act_r <= 0;
      pas_r <= 0;
    end else begin
      act_r <= link_receive_input ? act_r + 1 : 0;
      pas_r <= (link_receive_input || wr_ctrl) ? 0 : pas_r + 1;
      if (wr_ctrl) begin
        digital_loopback_r <= avs_writedata[0];
        analog_loopback_r <= avs_writedata[1];
        fast_r <= avs_writedata[2];
        resp_r <= avs_writedata[7:5];
      end
      // a break seen on the line wins over a same-cycle write
      if (act_r == 240 * CLK_MHZ)
        fast_r <= 1'b0;
      if (wr_ctrl && digital_loopback_r && !avs_writedata[0])
        gate_r <= 1'b1;
      else if (pas_r >= 299 * CLK_MHZ)
        gate_r <= 1'b0;
    end
  end
  sequence s_one_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  property p_one_wait;
    $rose(avs_read || avs_write) |-> s_one_wait;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("request not answered after one wait");
  property p_idle_nowait;
    !(avs_read || avs_write) |-> !avs_waitrequest;
  endproperty
  a_idle_nowait: assert property (p_idle_nowait) else $error("waitrequest without request");
  property p_unmapped;
    rd_ok && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_ctrl_back;
    rd_ok && avs_address == `JVL_ADDR_CTRL |->
      {avs_readdata[7:5], avs_readdata[1:0]} == {resp_r, analog_loopback_r, digital_loopback_r};
  endproperty
  a_ctrl_back: assert property (p_ctrl_back) else $error("control read-back differs");
  property p_digital_loopback_quiet;
    digital_loopback_r && $past(digital_loopback_r) |-> !link_transmit_output;
  endproperty
  a_digital_loopback_quiet: assert property (p_digital_loopback_quiet) else $error("pin driven in loopback");
  property p_analog_loopback_out;
    wr_ctrl |-> ##2 analog_loopback_out == analog_loopback_r;
  endproperty
  a_analog_loopback_out: assert property (p_analog_loopback_out) else $error("analog loop pin wrong");
  property p_analog_loopback_quiet;
    analog_loopback_out && $past(analog_loopback_out) |-> !link_transmit_output;
  endproperty
  a_analog_loopback_quiet: assert property (p_analog_loopback_quiet) else $error("bus driven in analog loop");
  property p_fast_quiet;
    fast_r && $past(fast_r) |-> !link_transmit_output;
  endproperty
  a_fast_quiet: assert property (p_fast_quiet) else $error("transmit in fast mode");
  property p_idle_gate;
    gate_r |-> !link_transmit_output;
  endproperty
  a_idle_gate: assert property (p_idle_gate) else $error("transmit before idle time");
endmodule

// file: verification/jvl_bus_node.sv
// far side of the link: wired bus line, vpw decoder and break source
// assumes passive low, active high dominant, a tick of CLK_MHZ clocks
`timescale 1ns/10ps
module jvl_bus_node #(
  parameter CLK_MHZ = 200
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic dev_tx,
  input wire logic break_req,
  output logic bus_level,
  output logic [23:0] rx_bytes,
  output logic [7:0] rx_count
);
  logic lvl_r, in_frame_r;
  logic [7:0] sh_r;
  logic [2:0] nb_r;
  int run_r, brk_r;
  wire logic bitv = lvl_r ? (run_r < 96 * CLK_MHZ) : (run_r >= 96 * CLK_MHZ);
  // wired line: any active driver wins, else it falls passive
  assign bus_level = dev_tx | (brk_r != 0);
  // break source holds the line active for 300 us
  always @(posedge clk) begin
    if (!resetn)
      brk_r <= 0;
    else if (break_req && brk_r == 0)
      brk_r <= 300 * CLK_MHZ;
    else if (brk_r != 0)
      brk_r <= brk_r - 1;
  end
  // symbol decoder; even bit count means every byte ends on a falling edge
  always @(posedge clk) begin
    if (!resetn) begin
      lvl_r <= 1'b0;
      run_r <= 0;
      in_frame_r <= 1'b0;
      nb_r <= 3'h0;
      sh_r <= 8'h00;
      rx_bytes <= 24'h0;
      rx_count <= 8'h00;
    end else if (bus_level != lvl_r) begin
      lvl_r <= bus_level;
      run_r <= 1;
      if (lvl_r && run_r >= 164 * CLK_MHZ) begin
        in_frame_r <= 1'b1;
        nb_r <= 3'h0;
      end else if (in_frame_r) begin
        sh_r <= {sh_r[6:0], bitv};
        nb_r <= nb_r + 3'h1;
        if (nb_r == 3'h7) begin
          rx_bytes <= {rx_bytes[15:0], sh_r[6:0], bitv};
          rx_count <= rx_count + 8'h01;
        end
      end
    end else begin
      run_r <= run_r + 1;
      if (!lvl_r && run_r >= 164 * CLK_MHZ)
        in_frame_r <= 1'b0;
    end
  end
endmodule

// file: verification/jvl_ctrl_test.sv
// self-checking bench for the vpw link control block
// assumes the bus node model on the link pins and a tick shortened to 4 clocks
`timescale 1ns/10ps
`include "jvl_map.vh"
module jvl_ctrl_test;
  localparam int MHZ = 4;
  typedef struct packed {logic wr; logic [3:0] a; logic [31:0] d; logic [31:0] m;} jvl_row_t;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic break_req = 1'b0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, link_transmit_output, analog_loopback_out, bus_level, seen;
  logic [23:0] rx_bytes;
  logic [7:0] rx_count;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  jvl_row_t rows [12];
  always #2.5 clk = ~clk;
  jvl_ctrl #(.CLK_MHZ(MHZ)) u_jvl_ctrl (.clk(clk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .link_receive_input(bus_level),
    .link_transmit_output(link_transmit_output), .analog_loopback_out(analog_loopback_out));
  jvl_bus_node #(.CLK_MHZ(MHZ)) u_jvl_bus_node (.clk(clk), .resetn(resetn),
    .dev_tx(link_transmit_output), .break_req(break_req), .bus_level(bus_level),
    .rx_bytes(rx_bytes), .rx_count(rx_count));
  task automatic finish_test();
    if (err_total == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask
  // poll a status bit; the watchdog bounds the wait
  task automatic wait_stat(input int b, input logic v);
    do xfer(1'b0, `JVL_ADDR_STAT, 32'h0); while (q[b] !== v);
  endtask
  function automatic logic [7:0] crc8(input logic [15:0] v);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h1D : 8'h00);
    return ~c;
  endfunction
  // cut a hang short; about 25k cycles are expected
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    // reset values, response bits set together on purpose, unmapped place
    rows = '{'{1'b0, 4'h0, 32'h00, 32'hFF}, '{1'b0, 4'h8, 32'h01, 32'h01},
      '{1'b0, 4'h4, 32'h00, 32'hFFFF}, '{1'b1, 4'h0, 32'hE0, 32'h0},
      '{1'b0, 4'h0, 32'hE0, 32'hE0}, '{1'b1, 4'h0, 32'h60, 32'h0},
      '{1'b0, 4'h0, 32'h60, 32'hE0}, '{1'b1, 4'h0, 32'h08, 32'h0},
      '{1'b0, 4'h0, 32'h08, 32'hFF}, '{1'b1, 4'h2, 32'hFF, 32'h0},
      '{1'b0, 4'h2, 32'h00, 32'hFFFFFFFF}, '{1'b1, 4'h0, 32'h00, 32'h0}};
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      xfer(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) chk("table read", rows[i].d, q & rows[i].m);
    end
    // analog loopback pin follows the bit
    xfer(1'b1, 4'h0, 32'h02);
    repeat (2) @(posedge clk);
    chk("analog_loopback pin", 32'h1, {31'h0, analog_loopback_out});
    xfer(1'b1, 4'h0, 32'h00);
    // digital loopback: frame stays inside and the byte comes back
    xfer(1'b1, 4'h0, 32'h01);
    xfer(1'b1, 4'hC, 32'hA5);
    wait_stat(`JVL_S_TX_DATA_EMPTY_FLAG, 1'b1);
    xfer(1'b1, 4'h0, 32'h11);
    xfer(1'b0, 4'h8, 32'h0);
    chk("tx_data_empty_flag after end request", 32'h0, q & 32'h1);
    wait_stat(`JVL_S_RXFULL, 1'b1);
    xfer(1'b0, 4'hC, 32'h0);
    chk("looped byte", 32'hA5, q & 32'hFF);
    wait_stat(`JVL_S_BUSY, 1'b0);
    xfer(1'b0, 4'h0, 32'h0);
    chk("end request after crc", 32'h0, q & 32'h10);
    chk("bus bytes in loopback", 32'h0, {24'h0, rx_count});
    // out of loopback: shift byte, shadow byte, then crc on the bus
    xfer(1'b1, 4'h0, 32'h00);
    xfer(1'b0, 4'h8, 32'h0);
    chk("idle wait after loopback", 32'h18, q & 32'h18);
    xfer(1'b1, 4'hC, 32'h3C);
    wait_stat(`JVL_S_TX_DATA_EMPTY_FLAG, 1'b1);
    xfer(1'b1, 4'hC, 32'hC3);
    xfer(1'b1, 4'h0, 32'h10);
    wait_stat(`JVL_S_BUSY, 1'b0);
    repeat (250 * MHZ) @(posedge clk);
    chk("bus byte count", 32'h3, {24'h0, rx_count});
    chk("frame bytes", {8'h0, 16'h3CC3, crc8(16'h3CC3)}, {8'h0, rx_bytes});
    xfer(1'b0, 4'h0, 32'h0);
    chk("end request after frame", 32'h0, q & 32'h10);
    // fast receive holds the pin; a break drops back to normal speed
    xfer(1'b1, 4'h0, 32'h04);
    xfer(1'b1, 4'hC, 32'h77);
    seen = 1'b0;
    repeat (400 * MHZ) begin
      @(posedge clk);
      if (link_transmit_output !== 1'b0) seen = 1'b1;
    end
    chk("pin in fast mode", 32'h0, {31'h0, seen});
    break_req <= 1'b1;
    @(posedge clk);
    break_req <= 1'b0;
    repeat (310 * MHZ) @(posedge clk);
    xfer(1'b0, 4'h4, 32'h0);
    chk("vector after break", 32'h001C, q & 32'hFFFF);
    xfer(1'b0, 4'h0, 32'h0);
    chk("fast bit after break", 32'h0, q & 32'h04);
    // second reset in mid-run
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    xfer(1'b0, 4'h0, 32'h0);
    chk("control after reset", 32'h0, q & 32'hFF);
    xfer(1'b0, 4'h8, 32'h0);
    chk("tx_data_empty_flag after reset", 32'h1, q & 32'h1);
    finish_test();
  end
endmodule
bind jvl_ctrl jvl_ctrl_sva #(.CLK_MHZ(CLK_MHZ)) u_jvl_ctrl_sva (.clk(clk), .resetn(resetn),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .link_receive_input(link_receive_input),
  .link_transmit_output(link_transmit_output), .analog_loopback_out(analog_loopback_out));
